// [design/ctw_pkg.sv]
// Package of opcodes, flag positions, cycle counts and state types for the test/transfer/wait decoder
`default_nettype none
package ctw_pkg;
    // Opcodes of the test-against-zero group
    localparam logic [7:0] OP_TEST_DIRECT = 8'h3d;
    localparam logic [7:0] OP_TEST_ACC = 8'h4d;
    localparam logic [7:0] OP_TEST_INDEX = 8'h5d;
    localparam logic [7:0] OP_TEST_IXBYTE = 8'h6d;
    localparam logic [7:0] OP_TEST_IXPLAIN = 8'h7d;
    // Opcodes of the transfer and wait instructions
    localparam logic [7:0] OP_COPY_INDEX_TO_ACC = 8'h9f;
    localparam logic [7:0] OP_WAIT = 8'h8f;
    // Upper nibbles that select the addressing mode of the memory-operand groups
    localparam logic [3:0] HI_BIT_BRANCH = 4'h0;
    localparam logic [3:0] HI_FULL_ADDRESS = 4'hc;
    localparam logic [3:0] HI_INDEXED_WORD = 4'hd;
    localparam logic [3:0] HI_INDEXED_BYTE = 4'he;
    localparam logic [3:0] HI_PLAIN_INDEXED = 4'hf;
    localparam logic [3:0] HI_DIRECT = 4'hb;
    // Condition code bit positions: H I N Z C
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;
    // Reset values
    localparam logic [7:0] CC_RESET = 8'he8;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // Total cycles of the two-cycle inherent instructions
    localparam logic [3:0] CYC_COPY_INDEX = 4'h2;
    localparam logic [3:0] CYC_WAIT = 4'h2;

    typedef enum logic [2:0] {
        CTW_FETCH,
        CTW_OPND_HI,
        CTW_OPND_LO,
        CTW_REL,
        CTW_READ,
        CTW_EXEC,
        CTW_HALT
    } ctw_state_type;

    typedef enum logic [2:0] {
        AM_NONE,
        AM_DIRECT,
        AM_FULL,
        AM_IX_WORD,
        AM_IX_BYTE,
        AM_IX_PLAIN,
        AM_BIT_BRANCH
    } ctw_mode_type;
endpackage : ctw_pkg
`default_nettype wire

// [design/ctw_addr_gen.sv]
// Effective address former for direct, full, and indexed addressing modes
`default_nettype none
module ctw_addr_gen (
    input wire ctw_pkg::ctw_mode_type mode_i,
    input wire logic [7:0] hi_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] index_i,
    output logic [15:0] addr_o
);
    always_comb begin
        case (mode_i)
            ctw_pkg::AM_FULL: addr_o = {hi_i, lo_i};
            ctw_pkg::AM_IX_WORD: addr_o = {hi_i, lo_i} + {8'h00, index_i};
            ctw_pkg::AM_IX_BYTE: addr_o = {8'h00, lo_i} + {8'h00, index_i};
            ctw_pkg::AM_IX_PLAIN: addr_o = {8'h00, index_i};
            default: addr_o = {8'h00, lo_i};
        endcase
    end
endmodule // ctw_addr_gen
`default_nettype wire

// [design/ctw_decode.sv]
// Fetch, decode and execute of test, index transfer, wait and operand-address forms
// Summary of operation
// - Test instructions set N and Z from the operand, store nothing, other flags kept.
// - Index-to-accumulator copy keeps all flags and takes two cycles.
// - Wait clears the interrupt mask, halts the CPU clock, takes two cycles.
// - Indexed word offset: fetch high then low byte, add to index register.
// - Full address mode: fetch high then low byte, use as operand address.
// - Indexed byte offset: fetch one offset byte, add to index register.
// - Bit branch: fetch direct address byte, then relative offset applied if taken.
`default_nettype none
module ctw_decode (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] fetch_data_i,
    input wire logic fetch_valid_i,
    input wire logic [7:0] mem_data_i,
    input wire logic mem_valid_i,
    input wire logic wake_i,
    output logic [15:0] pc_o,
    output logic fetch_req_o,
    output logic [15:0] mem_addr_o,
    output logic mem_req_o,
    output logic [7:0] acc_o,
    output logic [7:0] index_o,
    output logic [7:0] cc_o,
    output logic cpu_clk_halt_o,
    output logic instr_done_o
);
    ctw_pkg::ctw_state_type state_q;
    ctw_pkg::ctw_mode_type mode_q;
    ctw_pkg::ctw_mode_type mode_d;
    logic [7:0] opcode_q;
    logic [7:0] hi_q;
    logic [7:0] lo_q;
    logic [7:0] rel_q;
    logic [7:0] acc_q;
    logic [7:0] index_q;
    logic [7:0] cc_q;
    logic [15:0] pc_q;
    logic [15:0] ea;
    logic [7:0] operand;

    function automatic logic [7:0] flags_nz(input logic [7:0] cc, input logic [7:0] v);
        logic [7:0] r;
        r = cc;
        r[ctw_pkg::CC_N] = v[7];
        r[ctw_pkg::CC_Z] = (v == 8'h00);
        return r;
    endfunction

    function automatic ctw_pkg::ctw_mode_type mode_of(input logic [7:0] op);
        case (op[7:4])
            ctw_pkg::HI_BIT_BRANCH: mode_of = ctw_pkg::AM_BIT_BRANCH;
            ctw_pkg::HI_DIRECT: mode_of = ctw_pkg::AM_DIRECT;
            ctw_pkg::HI_FULL_ADDRESS: mode_of = ctw_pkg::AM_FULL;
            ctw_pkg::HI_INDEXED_WORD: mode_of = ctw_pkg::AM_IX_WORD;
            ctw_pkg::HI_INDEXED_BYTE: mode_of = ctw_pkg::AM_IX_BYTE;
            ctw_pkg::HI_PLAIN_INDEXED: mode_of = ctw_pkg::AM_IX_PLAIN;
            default: mode_of = ctw_pkg::AM_NONE;
        endcase
        if (op == ctw_pkg::OP_TEST_DIRECT) begin
            mode_of = ctw_pkg::AM_DIRECT;
        end
        if (op == ctw_pkg::OP_TEST_IXBYTE) begin
            mode_of = ctw_pkg::AM_IX_BYTE;
        end
        if (op == ctw_pkg::OP_TEST_IXPLAIN) begin
            mode_of = ctw_pkg::AM_IX_PLAIN;
        end
    endfunction

    assign mode_d = mode_of(fetch_data_i);

    ctw_addr_gen u_addr (
        .mode_i(mode_q),
        .hi_i(hi_q),
        .lo_i(lo_q),
        .index_i(index_q),
        .addr_o(ea)
    );

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= ctw_pkg::CTW_FETCH;
            mode_q <= ctw_pkg::AM_NONE;
            opcode_q <= 8'h00;
            hi_q <= 8'h00;
            lo_q <= 8'h00;
            rel_q <= 8'h00;
        end else begin
            case (state_q)
                ctw_pkg::CTW_FETCH: begin
                    if (fetch_valid_i) begin
                        opcode_q <= fetch_data_i;
                        mode_q <= mode_d;
                        hi_q <= 8'h00;
                        case (mode_d)
                            ctw_pkg::AM_FULL, ctw_pkg::AM_IX_WORD: state_q <= ctw_pkg::CTW_OPND_HI;
                            ctw_pkg::AM_DIRECT, ctw_pkg::AM_IX_BYTE,
                            ctw_pkg::AM_BIT_BRANCH: state_q <= ctw_pkg::CTW_OPND_LO;
                            ctw_pkg::AM_IX_PLAIN: state_q <= ctw_pkg::CTW_READ;
                            default: state_q <= ctw_pkg::CTW_EXEC;
                        endcase
                    end
                end
                ctw_pkg::CTW_OPND_HI: begin
                    if (fetch_valid_i) begin
                        hi_q <= fetch_data_i;
                        state_q <= ctw_pkg::CTW_OPND_LO;
                    end
                end
                ctw_pkg::CTW_OPND_LO: begin
                    if (fetch_valid_i) begin
                        lo_q <= fetch_data_i;
                        state_q <= (mode_q == ctw_pkg::AM_BIT_BRANCH) ? ctw_pkg::CTW_REL : ctw_pkg::CTW_READ;
                    end
                end
                ctw_pkg::CTW_REL: begin
                    if (fetch_valid_i) begin
                        rel_q <= fetch_data_i;
                        state_q <= ctw_pkg::CTW_READ;
                    end
                end
                ctw_pkg::CTW_READ: begin
                    if (mem_valid_i) begin
                        state_q <= ctw_pkg::CTW_EXEC;
                    end
                end
                ctw_pkg::CTW_EXEC: begin
                    state_q <= (opcode_q == ctw_pkg::OP_WAIT) ? ctw_pkg::CTW_HALT : ctw_pkg::CTW_FETCH;
                end
                ctw_pkg::CTW_HALT: begin
                    if (wake_i) begin
                        state_q <= ctw_pkg::CTW_FETCH;
                    end
                end
                default: state_q <= ctw_pkg::CTW_FETCH;
            endcase
        end
    end

    // Operand byte latched from memory
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            operand <= 8'h00;
        end else if (state_q == ctw_pkg::CTW_READ && mem_valid_i) begin
            operand <= mem_data_i;
        end
    end

    // Memory read request and address
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mem_req_o <= 1'b0;
            mem_addr_o <= 16'h0000;
        end else begin
            mem_req_o <= (state_q == ctw_pkg::CTW_READ) && !mem_valid_i;
            mem_addr_o <= ea;
        end
    end

    // Fetch request and program counter
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_q <= ctw_pkg::PC_RESET;
            fetch_req_o <= 1'b0;
        end else begin
            fetch_req_o <= (state_q == ctw_pkg::CTW_FETCH || state_q == ctw_pkg::CTW_OPND_HI ||
                            state_q == ctw_pkg::CTW_OPND_LO || state_q == ctw_pkg::CTW_REL);
            if (fetch_valid_i && (state_q == ctw_pkg::CTW_FETCH || state_q == ctw_pkg::CTW_OPND_HI ||
                                  state_q == ctw_pkg::CTW_OPND_LO || state_q == ctw_pkg::CTW_REL)) begin
                pc_q <= pc_q + 16'h0001;
            end else if (state_q == ctw_pkg::CTW_EXEC && mode_q == ctw_pkg::AM_BIT_BRANCH &&
                         (operand[opcode_q[3:1]] == ~opcode_q[0])) begin
                // Even opcodes branch on a set bit, odd ones on a clear bit
                pc_q <= pc_q + {{8{rel_q[7]}}, rel_q};
            end
        end
    end

    // Accumulator, index and condition codes
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_q <= ctw_pkg::ACC_RESET;
            index_q <= ctw_pkg::INDEX_RESET;
            cc_q <= ctw_pkg::CC_RESET;
        end else if (state_q == ctw_pkg::CTW_EXEC) begin
            case (opcode_q)
                ctw_pkg::OP_TEST_DIRECT, ctw_pkg::OP_TEST_IXBYTE,
                ctw_pkg::OP_TEST_IXPLAIN: cc_q <= flags_nz(cc_q, operand);
                ctw_pkg::OP_TEST_ACC: cc_q <= flags_nz(cc_q, acc_q);
                ctw_pkg::OP_TEST_INDEX: cc_q <= flags_nz(cc_q, index_q);
                ctw_pkg::OP_COPY_INDEX_TO_ACC: acc_q <= index_q;
                ctw_pkg::OP_WAIT: cc_q[ctw_pkg::CC_I] <= 1'b0;
                default: cc_q <= cc_q;
            endcase
        end
    end

    // Register file and status outputs, halt held until wake
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_o <= ctw_pkg::ACC_RESET;
            index_o <= ctw_pkg::INDEX_RESET;
            cc_o <= ctw_pkg::CC_RESET;
            pc_o <= ctw_pkg::PC_RESET;
            cpu_clk_halt_o <= 1'b0;
            instr_done_o <= 1'b0;
        end else begin
            acc_o <= acc_q;
            index_o <= index_q;
            cc_o <= cc_q;
            pc_o <= pc_q;
            cpu_clk_halt_o <= (state_q == ctw_pkg::CTW_HALT) && !wake_i;
            instr_done_o <= (state_q == ctw_pkg::CTW_EXEC);
        end
    end
endmodule // ctw_decode
`default_nettype wire

// [bench/ctw_decode_sva.sv]
// Port assertions for the test/transfer/wait decoder
`default_nettype none
module ctw_decode_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic mem_valid_i,
    input wire logic wake_i,
    input wire logic fetch_req_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_req_o,
    input wire logic [7:0] cc_o,
    input wire logic cpu_clk_halt_o,
    input wire logic instr_done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Register copies lag by a cycle, so skip two edges after any reset
    cc_keep_a: assert property ($past(rstn_i, 2) |-> $stable(cc_o[7:4]) && $stable(cc_o[0]))
        else $error("half carry, carry or spare flag moved");
    irq_fall_a: assert property ($past(rstn_i, 2) |-> !$rose(cc_o[3]))
        else $error("interrupt mask was set");
    halt_hold_a: assert property (cpu_clk_halt_o && !wake_i |=> cpu_clk_halt_o)
        else $error("halt dropped without wake");
    wake_exit_a: assert property (cpu_clk_halt_o && wake_i |-> ##[1:2] !cpu_clk_halt_o)
        else $error("halt kept after wake");
    halt_irq_a: assert property ($rose(cpu_clk_halt_o) |-> ##[0:3] !cc_o[3])
        else $error("halted with interrupts masked");
    done_pulse_a: assert property (instr_done_o |=> !instr_done_o)
        else $error("done longer than one cycle");
    halt_quiet_a: assert property (cpu_clk_halt_o |-> !fetch_req_o && !mem_req_o)
        else $error("bus activity while halted");
    mem_hold_a: assert property (mem_req_o && !mem_valid_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("read request or address moved");
    mem_excl_a: assert property (mem_req_o |-> !fetch_req_o)
        else $error("fetch and read at once");
endmodule // ctw_decode_chk

bind ctw_decode ctw_decode_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .mem_valid_i(mem_valid_i), .wake_i(wake_i),
    .fetch_req_o(fetch_req_o), .mem_addr_o(mem_addr_o), .mem_req_o(mem_req_o), .cc_o(cc_o),
    .cpu_clk_halt_o(cpu_clk_halt_o), .instr_done_o(instr_done_o));
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the test/transfer/wait decoder
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, fval = 0, mval = 0, wake = 0, freq, mreq, halt, done;
    logic [7:0] fdat = 8'h00, mdat = 8'h00, acc, idx, cc;
    logic [15:0] pc, maddr, nb = 16'h0000;
    int n_fail = 0, n_compared = 0, k;
    always #12.5 clk = ~clk;
    ctw_decode uut (.clk_i(clk), .rstn_i(rstn), .fetch_data_i(fdat), .fetch_valid_i(fval), .mem_data_i(mdat),
        .mem_valid_i(mval), .wake_i(wake), .pc_o(pc), .fetch_req_o(freq), .mem_addr_o(maddr), .mem_req_o(mreq),
        .acc_o(acc), .index_o(idx), .cc_o(cc), .cpu_clk_halt_o(halt), .instr_done_o(done));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Counts edges until the chosen condition; a hang ends the run
    task automatic wait_on(input int sel, output int n);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            n = i + 1;
            if ((sel == 0 && freq === 1'b1) || (sel == 1 && mreq === 1'b1) || (sel == 2 && done === 1'b1)
                    || (sel == 3 && halt === 1'b1) || (sel == 4 && halt === 1'b0))
                return;
        end
        chk(16'(sel), 16'hffff);
        complete_run();
    endtask
    // Valid stays up across operand bytes so it is never lowered and raised at one edge
    task automatic feed(input logic [7:0] b[$]);
        wait_on(0, k);
        foreach (b[j]) begin
            @(posedge clk);
            fdat <= b[j];
            fval <= 1'b1;
        end
        @(posedge clk);
        fval <= 1'b0;
        nb = nb + 16'(b.size());
    endtask
    task automatic serve(input logic [15:0] addr, input logic [7:0] d);
        wait_on(1, k);
        chk(maddr, addr);
        @(posedge clk);
        mdat <= d;
        mval <= 1'b1;
        @(posedge clk);
        mval <= 1'b0;
    endtask
    task automatic finish_op;
        wait_on(2, k);
        @(posedge clk);
        #1;
    endtask
    task automatic t_copy;
        feed('{8'h9f});
        wait_on(2, k);
        // The edge that takes the opcode is the first of the instruction's cycles
        chk(16'(k + 1), 16'(ctw_pkg::CYC_COPY_INDEX));
        @(posedge clk);
        #1;
        chk(16'(acc), 16'(ctw_pkg::INDEX_RESET));
        chk(16'(idx), 16'(ctw_pkg::INDEX_RESET));
        chk(16'(cc), 16'(ctw_pkg::CC_RESET));
    endtask
    task automatic t_test_inh(input logic [7:0] op);
        feed('{op});
        finish_op();
        chk(16'(cc), 16'h00ea);
    endtask
    task automatic run_mem(input logic [7:0] b[$], input logic [15:0] addr, input logic [7:0] d,
            input logic [1:0] nz);
        feed(b);
        serve(addr, d);
        finish_op();
        if (b[0][3:0] == 4'hd)
            chk(16'(cc[2:1]), 16'(nz));
    endtask
    // Opcode bit 0 clear branches when the tested bit is set; the operand has only bit 0 set
    task automatic t_branch(input logic [7:0] op, input logic [15:0] rel, input logic taken);
        feed('{op, 8'h20, rel[7:0]});
        serve(16'h0020, 8'h01);
        finish_op();
        // A taken branch moves the expected program counter for every later instruction too
        if (taken)
            nb = nb + rel;
        chk(pc, nb);
    endtask
    task automatic t_wait;
        feed('{8'h8f});
        wait_on(2, k);
        chk(16'(k + 1), 16'(ctw_pkg::CYC_WAIT));
        wait_on(3, k);
        repeat (5) @(posedge clk);
        #1;
        chk(16'(cc), 16'h00e0);
        chk(16'(halt), 16'h0001);
        @(posedge clk);
        wake <= 1'b1;
        wait_on(4, k);
        @(posedge clk);
        wake <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_copy();
        t_test_inh(8'h4d);
        t_test_inh(8'h5d);
        run_mem('{8'h3d, 8'h40}, 16'h0040, 8'h80, 2'b10);
        run_mem('{8'h6d, 8'hff}, 16'h00ff, 8'h00, 2'b01);
        run_mem('{8'h7d}, 16'h0000, 8'h7f, 2'b00);
        run_mem('{8'hc6, 8'h12, 8'h34}, 16'h1234, 8'h00, 2'b00);
        run_mem('{8'hd6, 8'hab, 8'hcd}, 16'habcd, 8'h00, 2'b00);
        t_branch(8'h00, 16'h0010, 1'b1);
        t_branch(8'h01, 16'h0005, 1'b0);
        t_wait();
        complete_run();
    end
endmodule // tb
`default_nettype wire
